// File: include/timer_pkg.sv
// Purpose: Shared constants and types for the timer prescaler and modulo block.
// Assumes: A 32-bit classic Wishbone slave with one 8-bit register in each word.
// Notes: Register offsets are byte addresses; data sits in bits 7:0.
package timer_pkg;

  // Byte addresses of the registers.
  localparam logic [7:0] ADR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADR_COUNTER_HIGH = 8'h04;
  localparam logic [7:0] ADR_COUNTER_LOW = 8'h08;
  localparam logic [7:0] ADR_MODULO_HIGH = 8'h0C;
  localparam logic [7:0] ADR_MODULO_LOW = 8'h10;

  // Field positions in timer_status_control.
  localparam int OVERFLOW_FLAG_BIT = 7;
  localparam int OVERFLOW_IRQ_ENABLE_BIT = 6;
  localparam int CENTER_PWM_SELECT_BIT = 5;
  localparam int CLOCK_SOURCE_MSB = 4;
  localparam int CLOCK_SOURCE_LSB = 3;
  localparam int PRESCALE_MSB = 2;
  localparam int PRESCALE_LSB = 0;

  // Clock source select codes.
  localparam logic [1:0] CLK_NONE = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXTERNAL = 2'h3;

  // Reset values and counter limits.
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'h0000;
  localparam logic [15:0] FREE_RUN_TOP = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] DIVIDE_ONE = 8'h01;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } bus_state_t;

endpackage

// File: src/timer_prescale_modulo.sv
// Purpose: Timebase of a 16-bit timer: clock source, prescaler, counter and modulo.
// Assumes: Debug, fixed-clock tick and loop-enable inputs come from logic on clk_i.
// Notes: Wishbone slave answers every request with ack one cycle after it is taken.
//
// Contract
// [R1] Clock source select: 00 none, 01 bus clock, 10 fixed clock, 11 external.
// [R2] Without an enabled locked loop, the fixed clock choice equals the bus clock.
// [R3] External source is synchronised inside; the fixed clock arrives synchronised.
// [R4] Prescaler divides the selected clock by two to the power of prescale_select.
// [R5] Prescaler follows synchronisation and selection of the source.
// [R6] A new prescale value acts from the next clock cycle.
// [R7] Reading either counter byte latches both until the other byte is read.
// [R8] Reset or a status/control write returns the read latch to idle.
// [R9] Any counter byte write clears the counter and the read latch.
// [R10] Reset clears the counter.
// [R11] In debug the counter freezes and the read latch holds its state.
// [R12] In debug, status/control or counter writes still reset the read latch.
// [R13] Counter at modulo wraps to zero on next count and sets overflow_flag.
// [R14] Half-written modulo suppresses overflow_flag until the other byte is written.
// [R15] Reset loads modulo zero, giving a free-running full-range counter.
// [R16] With no clock source, modulo loads once the second byte is written.
// [R17] With a source, modulo loads on the step from old modulo minus one.
// [R18] A status/control write resets the modulo write latch, debug or not.
// [R19] In debug the modulo write latch stays frozen unless reset by status write.
// [R20] In debug, modulo byte writes go straight to the active modulo.
// [R21] Software should clear the counter before setting a new modulo.
// [R22] overflow_flag clears by reading it set then writing zero; overflow restarts.
// [R23] overflow_irq_enable with overflow_flag set raises the interrupt request.
// [R24] Counter counts up; center_pwm_select makes it count up and down.
// [R25] Counter advances per prescaler pulse and holds with no source selected.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps

module timer_prescale_modulo
  import timer_pkg::*;
#(
  parameter int ADR_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic background_debug_mode_i,
  input wire logic loop_enabled_i,
  input wire logic fixed_tick_i,
  input wire logic external_clock_i,
  output logic overflow_irq_o,
  output logic [15:0] count_o,
  output logic count_down_o
);

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic overflow_flag;
    logic clear_armed;
    logic overflow_irq_enable;
    logic center_pwm_select;
    logic [1:0] clock_source_select;
    logic [2:0] prescale_select;
    logic [15:0] cnt;
    logic down;
    logic [6:0] presc;
    logic [15:0] cnt_buf;
    logic cnt_latched;
    logic cnt_first_high;
    logic [15:0] mod_live;
    logic [15:0] mod_buf;
    logic mod_high_seen;
    logic mod_low_seen;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic take;
  logic wr;
  logic rd;
  logic sc_wr;
  logic sc_rd;
  logic cnt_wr;
  logic cnt_rd;
  logic mod_wr;
  logic dbg;
  logic src_tick;
  logic ext_edge;
  logic [7:0] div_mask;
  logic cnt_tick;
  logic [15:0] top;
  logic at_top;
  logic half_mod;
  logic ovf;
  logic mod_due;

  assign dbg = background_debug_mode_i;
  assign take = cyc_i && stb_i && (st_r.bus == BUS_IDLE);
  assign wr = take && we_i && sel_i[0];
  assign rd = take && !we_i;
  assign sc_wr = wr && (adr_i == ADR_W'(ADR_STATUS_CONTROL));
  assign sc_rd = rd && (adr_i == ADR_W'(ADR_STATUS_CONTROL));
  assign cnt_wr = wr && ((adr_i == ADR_W'(ADR_COUNTER_HIGH)) || (adr_i == ADR_W'(ADR_COUNTER_LOW)));
  assign cnt_rd = rd && ((adr_i == ADR_W'(ADR_COUNTER_HIGH)) || (adr_i == ADR_W'(ADR_COUNTER_LOW)));
  assign mod_wr = wr && ((adr_i == ADR_W'(ADR_MODULO_HIGH)) || (adr_i == ADR_W'(ADR_MODULO_LOW)));

  // Only the second and third stages feed the edge detector.
  assign ext_edge = st_r.ext_s2 && !st_r.ext_s3; // R3

  always_comb
  begin
    case (st_r.clock_source_select) // R1
      CLK_BUS: src_tick = 1'b1;
      CLK_FIXED: src_tick = loop_enabled_i ? fixed_tick_i : 1'b1; // R2
      CLK_EXTERNAL: src_tick = ext_edge; // R3
      default: src_tick = 1'b0;
    endcase
  end

  // The divider works on the selected, synchronised tick, so a source change never glitches it.
  assign div_mask = (DIVIDE_ONE << st_r.prescale_select) - DIVIDE_ONE; // R4 R6
  assign cnt_tick = src_tick && !dbg && ((st_r.presc & div_mask[6:0]) == div_mask[6:0]); // R5 R25
  assign top = (st_r.mod_live == MODULO_RESET) ? FREE_RUN_TOP : st_r.mod_live; // R15
  assign at_top = (st_r.cnt == top);
  assign half_mod = st_r.mod_high_seen ^ st_r.mod_low_seen;
  assign ovf = cnt_tick && at_top && !st_r.down && !cnt_wr; // R13
  assign mod_due = st_r.mod_high_seen && st_r.mod_low_seen && cnt_tick && !st_r.down
    && (st_r.cnt == top - COUNT_ONE); // R17

  always_comb
  begin
    logic [7:0] rbyte;
    logic [15:0] live;
    rbyte = 8'h00;
    live = 16'h0000;
    st_nxt = st_r;
    st_nxt.ext_s1 = external_clock_i;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;

    if (src_tick && !dbg)
    begin
      st_nxt.presc = st_r.presc + 7'h01;
    end

    if (cnt_tick)
    begin
      if (!st_r.center_pwm_select)
      begin
        st_nxt.down = 1'b0;
        st_nxt.cnt = at_top ? COUNTER_RESET : st_r.cnt + COUNT_ONE; // R13 R24
      end
      else if (st_r.down)
      begin
        if (st_r.cnt == COUNTER_RESET)
        begin
          st_nxt.down = 1'b0;
          st_nxt.cnt = st_r.cnt + COUNT_ONE; // R24
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - COUNT_ONE;
        end
      end
      else if (at_top)
      begin
        st_nxt.down = 1'b1;
        st_nxt.cnt = st_r.cnt - COUNT_ONE; // R24
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + COUNT_ONE;
      end
    end

    if (mod_due)
    begin
      st_nxt.mod_live = st_r.mod_buf; // R17
      st_nxt.mod_high_seen = 1'b0;
      st_nxt.mod_low_seen = 1'b0;
    end

    // Register reads.
    if (rd)
    begin
      case (adr_i)
        ADR_W'(ADR_STATUS_CONTROL):
        begin
          rbyte = {st_r.overflow_flag, st_r.overflow_irq_enable, st_r.center_pwm_select,
                   st_r.clock_source_select, st_r.prescale_select};
          if (st_r.overflow_flag)
          begin
            st_nxt.clear_armed = 1'b1; // R22
          end
        end
        ADR_W'(ADR_COUNTER_HIGH),
        ADR_W'(ADR_COUNTER_LOW):
        begin
          live = st_r.cnt_latched ? st_r.cnt_buf : st_r.cnt; // R7 R11
          rbyte = (adr_i == ADR_W'(ADR_COUNTER_HIGH)) ? live[15:8] : live[7:0];
          if (!dbg)
          begin
            if (!st_r.cnt_latched)
            begin
              st_nxt.cnt_buf = st_r.cnt; // R7
              st_nxt.cnt_latched = 1'b1;
              st_nxt.cnt_first_high = (adr_i == ADR_W'(ADR_COUNTER_HIGH));
            end
            else if (st_r.cnt_first_high != (adr_i == ADR_W'(ADR_COUNTER_HIGH)))
            begin
              st_nxt.cnt_latched = 1'b0; // R7
            end
          end
        end
        ADR_W'(ADR_MODULO_HIGH): rbyte = st_r.mod_live[15:8];
        ADR_W'(ADR_MODULO_LOW): rbyte = st_r.mod_live[7:0];
        default: rbyte = 8'h00;
      endcase
    end

    // Register writes.
    if (sc_wr)
    begin
      st_nxt.overflow_irq_enable = dat_i[OVERFLOW_IRQ_ENABLE_BIT];
      st_nxt.center_pwm_select = dat_i[CENTER_PWM_SELECT_BIT];
      st_nxt.clock_source_select = dat_i[CLOCK_SOURCE_MSB:CLOCK_SOURCE_LSB];
      st_nxt.prescale_select = dat_i[PRESCALE_MSB:PRESCALE_LSB]; // R6
      if (!dat_i[OVERFLOW_FLAG_BIT] && st_r.clear_armed)
      begin
        st_nxt.overflow_flag = 1'b0; // R22
      end
      st_nxt.clear_armed = 1'b0;
      st_nxt.cnt_latched = 1'b0; // R8 R12
      st_nxt.mod_high_seen = 1'b0; // R18
      st_nxt.mod_low_seen = 1'b0;
    end

    if (cnt_wr)
    begin
      st_nxt.cnt = COUNTER_RESET; // R9
      st_nxt.down = 1'b0;
      st_nxt.cnt_latched = 1'b0; // R9 R12
    end

    if (mod_wr)
    begin
      if (dbg)
      begin
        // The write latch stays as it was; only the active value moves.
        if (adr_i == ADR_W'(ADR_MODULO_HIGH))
        begin
          st_nxt.mod_live[15:8] = dat_i[7:0]; // R20 R19
        end
        else
        begin
          st_nxt.mod_live[7:0] = dat_i[7:0]; // R20 R19
        end
      end
      else
      begin
        if (adr_i == ADR_W'(ADR_MODULO_HIGH))
        begin
          st_nxt.mod_buf[15:8] = dat_i[7:0];
          st_nxt.mod_high_seen = 1'b1;
        end
        else
        begin
          st_nxt.mod_buf[7:0] = dat_i[7:0];
          st_nxt.mod_low_seen = 1'b1;
        end
        if ((st_r.clock_source_select == CLK_NONE) && st_nxt.mod_high_seen && st_nxt.mod_low_seen)
        begin
          st_nxt.mod_live = st_nxt.mod_buf; // R16
          st_nxt.mod_high_seen = 1'b0;
          st_nxt.mod_low_seen = 1'b0;
        end
      end
    end

    // An overflow wins over a clear in the same cycle and restarts the clear sequence.
    if (ovf && !half_mod)
    begin
      st_nxt.overflow_flag = 1'b1; // R13 R14 R22
      st_nxt.clear_armed = 1'b0;
    end

    case (st_r.bus)
      BUS_IDLE:
      begin
        if (take)
        begin
          st_nxt.bus = BUS_ACK;
          st_nxt.rdata = READ_ZERO | 32'(rbyte);
        end
      end
      BUS_ACK: st_nxt.bus = BUS_IDLE;
      default: st_nxt.bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.bus <= BUS_IDLE;
      st_r.cnt <= COUNTER_RESET; // R10
      st_r.mod_live <= MODULO_RESET; // R15
      st_r.mod_buf <= MODULO_RESET;
      {st_r.overflow_flag, st_r.overflow_irq_enable, st_r.center_pwm_select,
       st_r.clock_source_select, st_r.prescale_select} <= STATUS_CONTROL_RESET;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign ack_o = (st_r.bus == BUS_ACK);
  assign dat_o = st_r.rdata;
  assign overflow_irq_o = st_r.overflow_flag && st_r.overflow_irq_enable; // R23
  assign count_o = st_r.cnt;
  assign count_down_o = st_r.down;

  // Every assertion gates on ce_i, because a low enable holds the state for one more cycle.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_bus_ack_next: assert property (ce_i && take |=> ack_o ##1 (!ack_o || !$past(ce_i)))
    else $error("bus request not acknowledged in the next cycle");
  a_wrap_to_zero: assert property (ce_i && ovf && !st_r.center_pwm_select |=> count_o == COUNTER_RESET) // R13
    else $error("counter did not wrap to zero at modulo");
  a_flag_on_wrap: assert property (ce_i && ovf && !half_mod |=> st_r.overflow_flag) // R13
    else $error("overflow flag not set at wrap");
  a_half_mod_quiet: assert property (ce_i && half_mod && !st_r.overflow_flag && !mod_wr |=> !st_r.overflow_flag) // R14
    else $error("overflow flag set while modulo half written");
  a_idle_holds: assert property (ce_i && st_r.clock_source_select == CLK_NONE && !cnt_wr |=> $stable(count_o)) // R25
    else $error("counter moved with no clock source");
  a_debug_freeze: assert property (ce_i && dbg && !cnt_wr |=> $stable(count_o)) // R11
    else $error("counter moved in debug mode");
  a_count_clear: assert property (ce_i && cnt_wr |=> count_o == COUNTER_RESET && !st_r.cnt_latched) // R9
    else $error("counter write did not clear counter and latch");
  a_status_unlatch: assert property (ce_i && sc_wr |=> !st_r.cnt_latched && !st_r.mod_high_seen) // R8 R12 R18
    else $error("status write did not reset the latches");
  a_flag_one_ignored: assert property (ce_i && sc_wr && !st_r.overflow_flag && !ovf |=> !st_r.overflow_flag) // R22
    else $error("writing the status register set the overflow flag");
  a_debug_direct: assert property (ce_i && dbg && mod_wr && adr_i == ADR_W'(ADR_MODULO_LOW) // R20
    |=> st_r.mod_live[7:0] == 8'($past(dat_i)))
    else $error("debug modulo write did not reach active modulo");
  a_prescale_two: assert property (ce_i && cnt_tick && st_r.prescale_select == 3'h1 && !st_r.center_pwm_select // R4
    && !at_top && !cnt_wr && !sc_wr ##1 ce_i && !cnt_wr && !sc_wr |-> !cnt_tick)
    else $error("divide by two counted twice in a row");
  a_irq_follows: assert property (ce_i && ovf && !half_mod && st_r.overflow_irq_enable && !sc_wr // R23
    |=> overflow_irq_o)
    else $error("interrupt request missing after overflow");
  a_clear_arm: assert property (ce_i && sc_rd && st_r.overflow_flag && !ovf |=> st_r.clear_armed) // R22
    else $error("status read with flag set did not arm the clear");

  c_overflow: cover property (ce_i && ovf);
  c_flag_cleared: cover property (st_r.overflow_flag ##1 !st_r.overflow_flag);
  c_mod_load: cover property (ce_i && mod_due);
  c_coherent_read: cover property (ce_i && cnt_rd && st_r.cnt_latched);
  c_center_turn: cover property (ce_i && cnt_tick && at_top && st_r.center_pwm_select);

endmodule

// File: test/timer_prescale_modulo_bench.sv
// Purpose: Self-checking bench for the timer prescaler, counter and modulo block.
// Assumes: Wishbone answers with a one-cycle ack; expectations come from the register map.
// Notes: Counter and ack are sampled at rising edges, so they show pre-edge values.
`timescale 1ns/1ps

module timer_prescale_modulo_bench;
  import timer_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  logic debug_mode_i = 1'b0;
  logic loop_i = 1'b0;
  logic tick_i = 1'b0;
  logic ext_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic irq_o;
  logic [15:0] count_o;
  logic down_o;
  int failures = 0;
  int check_count = 0;
  logic [7:0] q;
  logic [7:0] h;
  logic [15:0] c;

  always #2.5 clk_i = ~clk_i;

  timer_prescale_modulo dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .background_debug_mode_i(debug_mode_i), .loop_enabled_i(loop_i), .fixed_tick_i(tick_i),
    .external_clock_i(ext_i), .overflow_irq_o(irq_o), .count_o(count_o), .count_down_o(down_o));

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask

  // Holds the request until ack is sampled high; the next call leaves one idle cycle.
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h00_0000, d};
    sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      stop_test();
    end
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task rd(input logic [7:0] a, output logic [7:0] r);
    bus(a, 1'b0, 8'h00, r);
  endtask

  function automatic logic [7:0] sc(input logic [1:0] cs, input logic [2:0] pre, input logic ie);
    return {1'b0, ie, 1'b0, cs, pre};
  endfunction

  task reset_values;
    check("count", COUNTER_RESET, count_o);
    rd(ADR_STATUS_CONTROL, q);
    check("status", {8'h00, STATUS_CONTROL_RESET}, {8'h00, q});
    rd(ADR_MODULO_LOW, q);
    check("modulo", MODULO_RESET, {8'h00, q});
    $display("reset values done");
  endtask

  // Counts must step once every 2^k clocks, exactly, once aligned to a step.
  task rate(input logic [1:0] cs, input int k);
    int n;
    wr(ADR_STATUS_CONTROL, sc(cs, k[2:0], 1'b0));
    n = 0;
    c = count_o;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (count_o === c && n < 300);
    if (n >= 300)
    begin
      failures++;
      stop_test();
    end
    c = count_o;
    repeat (3 << k) @(posedge clk_i);
    check("count step", c + 16'h0003, count_o);
  endtask

  task prescale;
    for (int k = 0; k < 8; k++)
      rate(CLK_BUS, k);
    rate(CLK_FIXED, 0);
    @(posedge clk_i) loop_i <= 1'b1;
    wr(ADR_STATUS_CONTROL, sc(CLK_FIXED, 3'h0, 1'b0));
    wr(ADR_COUNTER_LOW, 8'h00);
    repeat (10)
    begin
      @(posedge clk_i) tick_i <= 1'b1;
      @(posedge clk_i) tick_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    @(posedge clk_i);
    check("fixed ticks", 16'h000a, count_o);
    @(posedge clk_i) loop_i <= 1'b0;
    wr(ADR_STATUS_CONTROL, sc(CLK_NONE, 3'h0, 1'b0));
    c = count_o;
    repeat (50) @(posedge clk_i);
    check("held count", c, count_o);
    $display("prescale done");
  endtask

  task external;
    wr(ADR_STATUS_CONTROL, sc(CLK_EXTERNAL, 3'h0, 1'b0));
    wr(ADR_COUNTER_LOW, 8'h5a);
    repeat (10)
    begin
      repeat (4) @(posedge clk_i) ext_i <= 1'b1;
      repeat (4) @(posedge clk_i) ext_i <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    check("external count", 16'h000a, count_o);
    $display("external done");
  endtask

  task coherent;
    wr(ADR_STATUS_CONTROL, sc(CLK_BUS, 3'h0, 1'b0));
    c = count_o;
    rd(ADR_COUNTER_LOW, q);
    repeat (300) @(posedge clk_i);
    rd(ADR_COUNTER_HIGH, h);
    check("low first", 16'h0001, {15'h0000, ({h, q} - c) < 16'h0005});
    c = count_o;
    rd(ADR_COUNTER_HIGH, h);
    repeat (300) @(posedge clk_i);
    rd(ADR_COUNTER_LOW, q);
    check("high first", 16'h0001, {15'h0000, ({h, q} - c) < 16'h0005});
    rd(ADR_COUNTER_LOW, q);
    repeat (600) @(posedge clk_i);
    wr(ADR_STATUS_CONTROL, sc(CLK_BUS, 3'h0, 1'b0));
    c = count_o;
    rd(ADR_COUNTER_HIGH, h);
    check("fresh high", 16'h0001, {15'h0000, (h - c[15:8]) < 8'h02});
    rd(ADR_COUNTER_LOW, q);
    wr(ADR_COUNTER_HIGH, 8'hff);
    check("cleared", 16'h0001, {15'h0000, count_o < 16'h0004});
    $display("coherent read done");
  endtask

  task modulo;
    int n;
    int top;
    wr(ADR_STATUS_CONTROL, sc(CLK_NONE, 3'h0, 1'b0));
    wr(ADR_MODULO_HIGH, 8'h00);
    wr(ADR_MODULO_LOW, 8'hff);
    rd(ADR_MODULO_LOW, q);
    check("modulo direct", 16'h00ff, {8'h00, q});
    wr(ADR_STATUS_CONTROL, sc(CLK_BUS, 3'h0, 1'b1));
    wr(ADR_COUNTER_LOW, 8'h00);
    n = 0;
    top = 0;
    while (irq_o !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      if (count_o > top)
        top = count_o;
      n++;
    end
    if (n >= 400)
    begin
      failures++;
      stop_test();
    end
    check("irq raised", 16'h0001, {15'h0000, irq_o});
    check("top", 16'h00ff, top[15:0]);
    rd(ADR_STATUS_CONTROL, q);
    check("flag", 16'h0001, {15'h0000, q[OVERFLOW_FLAG_BIT]});
    wr(ADR_STATUS_CONTROL, sc(CLK_BUS, 3'h0, 1'b1));
    @(posedge clk_i);
    check("irq cleared", 16'h0000, {15'h0000, irq_o});
    wr(ADR_COUNTER_LOW, 8'h00);
    wr(ADR_MODULO_HIGH, 8'h00);
    repeat (300) @(posedge clk_i);
    check("irq suppressed", 16'h0000, {15'h0000, irq_o});
    wr(ADR_MODULO_LOW, 8'h7f);
    rd(ADR_MODULO_LOW, q);
    check("old modulo", 16'h00ff, {8'h00, q});
    repeat (300) @(posedge clk_i);
    rd(ADR_MODULO_LOW, q);
    check("new modulo", 16'h007f, {8'h00, q});
    $display("modulo done");
  endtask

  task debug;
    @(posedge clk_i) debug_mode_i <= 1'b1;
    @(posedge clk_i);
    c = count_o;
    repeat (30) @(posedge clk_i);
    check("frozen", c, count_o);
    wr(ADR_MODULO_LOW, 8'h33);
    rd(ADR_MODULO_LOW, q);
    check("debug modulo", 16'h0033, {8'h00, q});
    @(posedge clk_i) debug_mode_i <= 1'b0;
    @(posedge clk_i) ce_i <= 1'b0;
    @(posedge clk_i);
    c = count_o;
    repeat (20) @(posedge clk_i);
    check("enable frozen", c, count_o);
    @(posedge clk_i) ce_i <= 1'b1;
    $display("debug done");
  endtask

  // Center mode turns down at the modulo value and up again at zero.
  task center;
    int n;
    wr(ADR_STATUS_CONTROL, sc(CLK_NONE, 3'h0, 1'b0));
    wr(ADR_COUNTER_LOW, 8'h00);
    wr(ADR_MODULO_HIGH, 8'h00);
    wr(ADR_MODULO_LOW, 8'h04);
    wr(ADR_STATUS_CONTROL, sc(CLK_BUS, 3'h0, 1'b0) | 8'(1 << CENTER_PWM_SELECT_BIT));
    n = 0;
    while (down_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    check("turn down", 16'h0003, count_o);
    while (down_o !== 1'b0 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100)
    begin
      failures++;
      stop_test();
    end
    check("turn up", 16'h0001, count_o);
    $display("center done");
  endtask

  // A second reset in mid-run must bring back the counter, status/control and low modulo byte reset values.
  task restart;
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    prescale();
    external();
    coherent();
    modulo();
    debug();
    center();
    restart();
    stop_test();
  end
endmodule
